//--- sfrm_top.sv
// special function region plus general purpose ram, driven by the core
// assumes one core access per cycle; read data valid the cycle after the request
`timescale 1ns/10ps
`include "sfrm_defines.svh"
module sfrm_top (
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic BANK,
	input wire sfrm_pkg::sfrm_req_t REQ,
	input wire sfrm_pkg::sfrm_core_t CORE,
	input wire logic [7:0] STATUS_HW,
	output logic [7:0] RDATA,
	output logic [7:0] ALU_HOLDER,
	output logic [7:0] PTR_A,
	output logic [7:0] PTR_B,
	output logic [7:0] PC_LOW,
	output logic PC_JUMP,
	output logic DUMMY_CYCLE,
	output logic [7:0] TABLE_PTR
);
	// general purpose ram, never reset: its contents are undefined at power up
	logic [7:0] gp_mem [0:`SFRM_GP_WORDS-1];

	// one byte per special location; gaps are never written and so read zero
	logic [7:0] sfr_mem [0:`SFRM_SPECIAL_LAST];

	// address after the indirect port has been resolved to its pointer
	logic [7:0] eff_addr;

	// set when an indirect access lands on a port address itself
	logic ind_null;

	// value captured into the read data register on a read
	logic [7:0] next_rdata;

	// decoded region of the resolved address
	logic in_gp;
	logic in_sfr;

	// offset into the general ram and into the special storage
	logic [6:0] gp_idx;
	logic [`SFRM_SFR_IDX_MSB:0] sfr_idx;

	// location classes of the resolved address
	logic loc_plain;
	logic loc_masked;

	// qualified write strobes
	logic wr_ok;
	logic sfr_we;
	logic [7:0] sfr_wdata;

	// pointer selection; port address itself never stored
	always_comb begin
		eff_addr = REQ.addr;
		ind_null = 1'b0;
		if (REQ.addr == `SFRM_ADDR_IND_A) begin // RULE_05
			eff_addr = PTR_A; // RULE_04 RULE_14
		end else if (REQ.addr == `SFRM_ADDR_IND_B) begin
			eff_addr = PTR_B; // RULE_04 RULE_14
		end
		if (eff_addr == `SFRM_ADDR_IND_A || eff_addr == `SFRM_ADDR_IND_B) begin
			ind_null = 1'b1; // RULE_03 RULE_06
		end
	end

	// general ram follows the special region directly, bank zero only
	assign in_gp = (eff_addr >= `SFRM_GP_FIRST) && (eff_addr <= `SFRM_GP_LAST) && (BANK == `SFRM_BANK0); // RULE_11
	assign in_sfr = (eff_addr <= `SFRM_SPECIAL_LAST); // RULE_02
	assign gp_idx = 7'(eff_addr - `SFRM_GP_FIRST);
	assign sfr_idx = eff_addr[`SFRM_SFR_IDX_MSB:0];

	// a write that the port filter lets through
	assign wr_ok = REQ.wr && !ind_null;

	// classify each special location by how a core write treats it
	always_comb begin
		loc_plain = 1'b0;
		loc_masked = 1'b0;
		case (eff_addr)
			`SFRM_ADDR_WDOG_SEL: loc_plain = 1'b1;
			`SFRM_ADDR_INT_CTRL_A: loc_plain = 1'b1;
			`SFRM_ADDR_TIMER_A: loc_plain = 1'b1;
			`SFRM_ADDR_TIMER_CTRL_A: loc_plain = 1'b1;
			`SFRM_ADDR_TIMER_B: loc_plain = 1'b1;
			`SFRM_ADDR_TIMER_CTRL_B: loc_plain = 1'b1;
			`SFRM_ADDR_PORT_A_DATA: loc_plain = 1'b1;
			`SFRM_ADDR_PORT_A_DIR: loc_plain = 1'b1;
			`SFRM_ADDR_PORT_A_PULL: loc_plain = 1'b1;
			`SFRM_ADDR_PORT_A_WAKE: loc_plain = 1'b1;
			`SFRM_ADDR_PORT_B_DATA: loc_plain = 1'b1;
			`SFRM_ADDR_PORT_B_DIR: loc_plain = 1'b1;
			`SFRM_ADDR_PORT_B_PULL: loc_plain = 1'b1;
			`SFRM_ADDR_SYS_CTRL_A: loc_plain = 1'b1;
			`SFRM_ADDR_SYS_CTRL_B: loc_plain = 1'b1;
			`SFRM_ADDR_INT_CTRL_B: loc_plain = 1'b1;
			`SFRM_ADDR_PWM_DUTY: loc_plain = 1'b1;
			`SFRM_ADDR_CONV_CTRL: loc_plain = 1'b1;
			`SFRM_ADDR_CONV_CLK: loc_plain = 1'b1;
			// flag bits 5:4 come from STATUS_HW and bits 7:6 read zero; the core writes only the low nibble
			`SFRM_ADDR_STATUS: loc_masked = 1'b1; // RULE_10
			// read-only: only the table load may change the table high byte; the converter bytes stay at zero
			`SFRM_ADDR_TABLE_HIGH: loc_plain = 1'b0; // RULE_10 RULE_12
			`SFRM_ADDR_CONV_LOW: loc_plain = 1'b0; // RULE_10
			`SFRM_ADDR_CONV_HIGH: loc_plain = 1'b0; // RULE_10
			// gaps and reserved space keep their reset zero
			default: loc_plain = 1'b0; // RULE_01
		endcase
	end

	// dedicated registers live in their own flops, so they are not classed here
	assign sfr_we = wr_ok && in_sfr && (loc_plain || loc_masked);
	assign sfr_wdata = loc_masked ? (REQ.wdata & `SFRM_STATUS_WMASK) : REQ.wdata;

	// only registers that this block keeps return data; all others read zero
	always_comb begin
		next_rdata = `SFRM_ZERO; // RULE_01
		if (!ind_null && in_gp) begin
			next_rdata = gp_mem[gp_idx];
		end else if (!ind_null && in_sfr) begin
			case (eff_addr)
				`SFRM_ADDR_PTR_A: next_rdata = PTR_A; // RULE_07
				`SFRM_ADDR_PTR_B: next_rdata = PTR_B; // RULE_07
				`SFRM_ADDR_ALU_HOLDER: next_rdata = ALU_HOLDER; // RULE_08
				`SFRM_ADDR_PC_LOW: next_rdata = PC_LOW;
				`SFRM_ADDR_TABLE_PTR: next_rdata = TABLE_PTR;
				`SFRM_ADDR_STATUS: next_rdata = (sfr_mem[sfr_idx] & `SFRM_STATUS_WMASK) |
					(STATUS_HW & `SFRM_STATUS_RMASK & ~`SFRM_STATUS_WMASK);
				default: next_rdata = sfr_mem[sfr_idx];
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			RDATA <= `SFRM_ZERO;
		end else if (REQ.rd) begin
			RDATA <= next_rdata;
		end
	end

	// general ram storage only, never reset; sfr storage and its write protection follow below
	always_ff @(posedge CLK_SYS) begin
		if (REQ.wr && !ind_null && in_gp) begin
			gp_mem[gp_idx] <= REQ.wdata;
		end
	end

	// one storage byte per special location; a table load must not be lost
	// to an unrelated register write in the same cycle
	genvar g;
	generate
		for (g = 0; g <= `SFRM_SPECIAL_LAST; g = g + 1) begin : g_sfr
			always_ff @(posedge CLK_SYS) begin
				if (!RESETN) begin
					sfr_mem[g] <= `SFRM_ZERO;
				end else if (sfr_we && eff_addr == 8'(g)) begin
					sfr_mem[g] <= sfr_wdata; // RULE_10
				end else if (CORE.tbl_we && 8'(g) == `SFRM_ADDR_TABLE_HIGH) begin
					sfr_mem[g] <= CORE.tbl_high; // RULE_12
				end
			end
		end
	endgenerate

	// pointers are plain storage; bit operations are read then write by the core
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			PTR_A <= `SFRM_ZERO;
			PTR_B <= `SFRM_ZERO;
		end else if (REQ.wr && !ind_null) begin
			if (eff_addr == `SFRM_ADDR_PTR_A) begin
				PTR_A <= REQ.wdata; // RULE_07
			end
			if (eff_addr == `SFRM_ADDR_PTR_B) begin
				PTR_B <= REQ.wdata; // RULE_07
			end
		end
	end

	// alu result wins over a memory write; core never copies register to register directly
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			ALU_HOLDER <= `SFRM_ZERO;
		end else if (CORE.alu_we) begin
			ALU_HOLDER <= CORE.alu_result; // RULE_08 RULE_09
		end else if (wr_ok && eff_addr == `SFRM_ADDR_ALU_HOLDER) begin
			ALU_HOLDER <= REQ.wdata; // RULE_08
		end
	end

	// table pointer feeds the table read logic outside this block
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			TABLE_PTR <= `SFRM_ZERO;
		end else if (wr_ok && eff_addr == `SFRM_ADDR_TABLE_PTR) begin
			TABLE_PTR <= REQ.wdata;
		end
	end

	// pcl write requests an in-page jump; dummy cycle follows the jump pulse
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			PC_LOW <= `SFRM_ZERO;
			PC_JUMP <= 1'b0;
			DUMMY_CYCLE <= 1'b0;
		end else begin
			PC_JUMP <= 1'b0;
			DUMMY_CYCLE <= PC_JUMP; // RULE_13
			if (wr_ok && eff_addr == `SFRM_ADDR_PC_LOW) begin
				PC_LOW <= REQ.wdata;
				PC_JUMP <= 1'b1; // RULE_13
			end
		end
	end
endmodule : sfrm_top

//--- sfrm_defines.svh
// special function register map constants: offsets, sizes, reset values
// assumes a single 8-bit data memory space starting at zero, first bank
// Summary of operation
// (RULE_01) unimplemented special locations and reserved gaps read back as zero
// (RULE_02) special region begins at data address zero in bank zero
// (RULE_03) indirect port addresses hold no storage of their own
// (RULE_04) indirect port access lands on the location its pointer names
// (RULE_05) first port always uses first pointer, second port the second
// (RULE_06) pointer naming a port: indirect read gives zero, write does nothing
// (RULE_07) both pointers are real readable, writable, bit-settable storage
// (RULE_08) accumulator takes alu results and is readable and writable in memory
// (RULE_09) no direct register-to-register copy; transfers pass through accumulator
// (RULE_10) most registers read and write; protected ones ignore writes
// (RULE_11) all locations are eight bits wide, sections consecutive
// (RULE_12) table data high byte is read-only, loaded only by table reads
// (RULE_13) program counter low write jumps within page and adds a dummy cycle
// (RULE_14) pointer supplies full eight-bit address on the same access cycle
`ifndef SFRM_DEFINES_SVH
`define SFRM_DEFINES_SVH
`define SFRM_BANK0 1'h0
`define SFRM_ADDR_IND_A 8'h00
`define SFRM_ADDR_PTR_A 8'h01
`define SFRM_ADDR_IND_B 8'h02
`define SFRM_ADDR_PTR_B 8'h03
`define SFRM_ADDR_ALU_HOLDER 8'h05
`define SFRM_ADDR_PC_LOW 8'h06
`define SFRM_ADDR_TABLE_PTR 8'h07
`define SFRM_ADDR_TABLE_HIGH 8'h08
`define SFRM_ADDR_WDOG_SEL 8'h09
`define SFRM_ADDR_STATUS 8'h0a
`define SFRM_ADDR_INT_CTRL_A 8'h0b
`define SFRM_ADDR_TIMER_A 8'h0c
`define SFRM_ADDR_TIMER_CTRL_A 8'h0d
`define SFRM_ADDR_TIMER_B 8'h0e
`define SFRM_ADDR_TIMER_CTRL_B 8'h0f
`define SFRM_ADDR_PORT_A_DATA 8'h10
`define SFRM_ADDR_PORT_A_DIR 8'h11
`define SFRM_ADDR_PORT_A_PULL 8'h12
`define SFRM_ADDR_PORT_A_WAKE 8'h13
`define SFRM_ADDR_PORT_B_DATA 8'h14
`define SFRM_ADDR_PORT_B_DIR 8'h15
`define SFRM_ADDR_PORT_B_PULL 8'h16
`define SFRM_ADDR_SYS_CTRL_A 8'h1a
`define SFRM_ADDR_SYS_CTRL_B 8'h1b
`define SFRM_ADDR_INT_CTRL_B 8'h1e
`define SFRM_ADDR_PWM_DUTY 8'h1f
`define SFRM_ADDR_CONV_LOW 8'h20
`define SFRM_ADDR_CONV_HIGH 8'h21
`define SFRM_ADDR_CONV_CTRL 8'h22
`define SFRM_ADDR_CONV_CLK 8'h23
`define SFRM_SPECIAL_LAST 8'h3f
`define SFRM_SFR_IDX_MSB 5
`define SFRM_GP_FIRST 8'h40
`define SFRM_GP_LAST 8'h9f
`define SFRM_GP_WORDS 96
`define SFRM_STATUS_WMASK 8'h0f
`define SFRM_STATUS_RMASK 8'h3f
`define SFRM_ZERO 8'h00
`endif

//--- sfrm_pkg.sv
// types for the special function register map
// assumes sfrm_defines.svh is included before use
package sfrm_pkg;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfrm_req_t;
	typedef struct packed {
		logic alu_we;
		logic [7:0] alu_result;
		logic tbl_we;
		logic [7:0] tbl_high;
	} sfrm_core_t;
endpackage : sfrm_pkg

//--- sfrm_top_asserts.sv
// assertions over the sfrm_top ports
// assumes one core access per cycle
`timescale 1ns/10ps
module sfrm_top_asserts (
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire sfrm_pkg::sfrm_req_t REQ,
	input wire sfrm_pkg::sfrm_core_t CORE,
	input wire logic [7:0] STATUS_HW,
	input wire logic [7:0] RDATA,
	input wire logic [7:0] ALU_HOLDER,
	input wire logic [7:0] PTR_A,
	input wire logic PC_JUMP,
	input wire logic DUMMY_CYCLE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	sequence s_pcl; REQ.wr && REQ.addr == 8'h06; endsequence
	sequence s_tbl; CORE.tbl_we ##2 REQ.rd && REQ.addr == 8'h08; endsequence
	property p_ptr; REQ.wr && REQ.addr == 8'h01 |=> PTR_A == $past(REQ.wdata); endproperty
	a_ptr: assert property (p_ptr) else $error("ptr");
	property p_rdp; REQ.rd && REQ.addr == 8'h01 |=> RDATA == $past(PTR_A); endproperty
	a_rdp: assert property (p_rdp) else $error("ptr rd");
	property p_alu; CORE.alu_we |=> ALU_HOLDER == $past(CORE.alu_result); endproperty
	a_alu: assert property (p_alu) else $error("alu");
	property p_accw; REQ.wr && REQ.addr == 8'h05 && !CORE.alu_we |=> ALU_HOLDER == $past(REQ.wdata); endproperty
	a_accw: assert property (p_accw) else $error("acc");
	property p_pcl; s_pcl |=> PC_JUMP ##1 DUMMY_CYCLE; endproperty
	a_pcl: assert property (p_pcl) else $error("pcl");
	property p_zero; REQ.rd && (REQ.addr == 8'h04 || REQ.addr > 8'h9f) |=> RDATA == 8'h00; endproperty
	a_zero: assert property (p_zero) else $error("zero");
	property p_tbl; s_tbl |=> RDATA == $past(CORE.tbl_high, 3); endproperty
	a_tbl: assert property (p_tbl) else $error("tbl");
	property p_stat; REQ.rd && REQ.addr == 8'h0a |=> RDATA[7:4] == {2'h0, $past(STATUS_HW[5:4])}; endproperty
	a_stat: assert property (p_stat) else $error("status");
endmodule : sfrm_top_asserts
bind sfrm_top sfrm_top_asserts i_sfrm_top_asserts (.*);

//--- sfrm_core_model.sv
// core model: data accesses plus alu and table loads
// assumes inputs change on the falling edge
`timescale 1ns/10ps
module sfrm_core_model (
	input wire logic CLK_SYS,
	output sfrm_pkg::sfrm_req_t REQ,
	output sfrm_pkg::sfrm_core_t CORE,
	output logic BANK,
	output logic [7:0] STATUS_HW
);
	initial begin
		REQ = '0;
		CORE = '0;
		BANK = 1'h0;
		STATUS_HW = 8'h30;
	end
	// one location per access, copies go by the accumulator
	task op(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge CLK_SYS);
		REQ = {~w, w, a, d};
		@(negedge CLK_SYS);
		REQ = {2'h0, a, ~d};
	endtask : op
	task sel(input logic b);
		@(negedge CLK_SYS);
		BANK = b;
	endtask : sel
	task ld(input logic t, input logic [7:0] v);
		@(negedge CLK_SYS);
		CORE = t ? {9'h0, 1'h1, v} : {1'h1, v, 9'h0};
		@(negedge CLK_SYS);
		CORE = '0;
	endtask : ld
endmodule : sfrm_core_model

//--- test_sfrm_top.sv
// self-checking bench for sfrm_top
// assumes a 100 ns clock
`timescale 1ns/10ps
module test_sfrm_top;
	logic CLK_SYS = 1'h0;
	logic RESETN = 1'h0;
	sfrm_pkg::sfrm_req_t REQ;
	sfrm_pkg::sfrm_core_t CORE;
	logic BANK, PC_JUMP, DUMMY_CYCLE;
	logic [7:0] STATUS_HW, RDATA, ALU_HOLDER, PTR_A, PTR_B, PC_LOW, TABLE_PTR;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	sfrm_top i_sfrm_top (.*);
	sfrm_core_model i_sfrm_core_model (.*);
	initial begin
		forever #50 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			close_out;
		end
	end
	task chk(input logic [7:0] s, input logic [7:0] e, input string n);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task w(input logic [7:0] a, input logic [7:0] d);
		i_sfrm_core_model.op(1'h1, a, d);
	endtask : w
	task rc(input logic [7:0] a, input logic [7:0] e);
		i_sfrm_core_model.op(1'h0, a, 8'h00);
		chk(RDATA, e, "rdata");
	endtask : rc
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task t_ind;
		w(8'h01, 8'h50);
		w(8'h03, 8'h9f);
		w(8'h00, 8'h11);
		w(8'h02, 8'h22);
		rc(8'h50, 8'h11);
		rc(8'h9f, 8'h22);
		rc(8'h00, 8'h11);
		rc(8'h01, 8'h50);
		chk(PTR_B, 8'h9f, "ptr_b");
		i_sfrm_core_model.sel(1'h1);
		rc(8'h50, 8'h00);
		i_sfrm_core_model.sel(1'h0);
		rc(8'h50, 8'h11);
		w(8'h01, 8'h02);
		w(8'h00, 8'h77);
		rc(8'h00, 8'h00);
		w(8'h01, 8'h00);
		rc(8'h00, 8'h00);
		$display("done ind");
	endtask : t_ind
	task t_ro;
		i_sfrm_core_model.ld(1'h1, 8'h5a);
		rc(8'h08, 8'h5a);
		w(8'h0c, 8'h44);
		rc(8'h0c, 8'h44);
		w(8'h08, 8'hff);
		rc(8'h08, 8'h5a);
		w(8'h0a, 8'hff);
		rc(8'h0a, 8'h3f);
		w(8'h20, 8'hff);
		rc(8'h20, 8'h00);
		w(8'h04, 8'hff);
		rc(8'h04, 8'h00);
		rc(8'h24, 8'h00);
		$display("done ro");
	endtask : t_ro
	task t_acc;
		i_sfrm_core_model.ld(1'h0, 8'hc3);
		rc(8'h05, 8'hc3);
		w(8'h05, 8'h3c);
		chk(ALU_HOLDER, 8'h3c, "alu_holder");
		w(8'h07, 8'h66);
		chk(TABLE_PTR, 8'h66, "table_ptr");
		rc(8'h07, 8'h66);
		w(8'h06, 8'h12);
		chk(PC_LOW, 8'h12, "pc_low");
		chk(PC_JUMP, 8'h01, "pc_jump");
		@(negedge CLK_SYS);
		chk(PC_JUMP, 8'h00, "pc_jump_end");
		chk(DUMMY_CYCLE, 8'h01, "dummy");
		$display("done acc");
	endtask : t_acc
	task t_rst;
		@(negedge CLK_SYS);
		RESETN = 1'h0;
		@(negedge CLK_SYS);
		RESETN = 1'h1;
		chk(PTR_A, 8'h00, "ptr_a_rst");
		chk(ALU_HOLDER, 8'h00, "alu_rst");
		rc(8'h05, 8'h00);
		$display("done rst");
	endtask : t_rst
	initial begin
		repeat (2) @(negedge CLK_SYS);
		RESETN = 1'h1;
		t_ind;
		t_ro;
		t_acc;
		t_rst;
		close_out;
	end
endmodule : test_sfrm_top
